// File: port_mode_config_decode.sv
// file: per-port configuration, converter code and result register bank
`timescale 1ns/1ps
module port_mode_config_decode
  import port_mode_pkg::*;
#(
  parameter int PORTS = NUM_PORTS  // number of ports
)(
  // clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_b_in,
  // register write port from the serial interface
  input  wire logic                   cfg_wr_in,
  input  wire logic                   code_wr_in,
  input  wire logic [PORT_IDX_W-1:0]  wr_port_in,
  input  wire logic [15:0]            wr_data_in,
  // register read port
  input  wire logic [PORT_IDX_W-1:0]  rd_port_in,
  output logic      [15:0]            cfg_rd_out,
  output logic      [15:0]            code_rd_out,
  output logic      [15:0]            result_rd_out,
  // output level register bits, one per port
  input  wire logic [PORTS-1:0]       output_level_bits_in,
  // converter side: raw conversion results and strobe
  input  wire logic                   conv_done_in,
  input  wire logic [PORT_IDX_W-1:0]  conv_port_in,
  input  wire logic [11:0]            conv_raw_in,
  // decoded per-port controls to the analog front end
  output logic [PORTS-1:0][3:0]       port_mode_out,
  output logic [PORTS-1:0][2:0]       port_range_out,
  output logic [PORTS-1:0][2:0]       port_avg_out,
  output logic [PORTS-1:0]            port_ref_sel_out,
  output logic [PORTS-1:0]            port_adc_en_out,
  output logic [PORTS-1:0]            port_dac_en_out,
  output logic [PORTS-1:0][11:0]      port_dac_code_out,
  output logic [PORTS-1:0]            port_gpo_level_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////////////////

  // whole register bank in one packed struct
  typedef struct packed {
    logic [PORTS-1:0][15:0] cfg;     // configuration words
    logic [PORTS-1:0][11:0] code;    // output converter codes
    logic [PORTS-1:0][11:0] result;  // stored conversion results
    logic [15:0]            cfg_rd;
    logic [15:0]            code_rd;
    logic [15:0]            result_rd;
  } bank_state_t;

  bank_state_t state_reg;   // registered state
  bank_state_t state_next;  // next state

  port_decode_t dec [PORTS];  // decoded function per port

  ////////////////////////////////////////////////////////////////////////////
  // per-port decoders
  ////////////////////////////////////////////////////////////////////////////

  // one decoder per port, fed by its stored word
  generate
    for (genvar p = 0; p < PORTS; p++) begin : g_dec
      port_function_decode u_dec (
        .cfg_word_in (state_reg.cfg[p]),
        .decode_out  (dec[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state
  ////////////////////////////////////////////////////////////////////////////

  // writes, result capture and read-back mux
  always_comb begin
    state_next = state_reg;
    // configuration write from host
    if (cfg_wr_in && (wr_port_in < PORT_IDX_W'(PORTS))) begin
      state_next.cfg[wr_port_in] = wr_data_in;
    end
    // output code write; upper nibble dropped
    if (code_wr_in && (wr_port_in < PORT_IDX_W'(PORTS))) begin
      state_next.code[wr_port_in] = wr_data_in[11:0];
    end
    // capture conversion result of an enabled converter port
    if (conv_done_in && (conv_port_in < PORT_IDX_W'(PORTS))) begin
      if (dec[conv_port_in].adc_enable) begin
        // raw is passed through: straight binary in 6/7, two's complement in 8
        state_next.result[conv_port_in] = conv_raw_in;
      end
    end
    // negative-input ports hold zero whatever happens
    for (int p = 0; p < PORTS; p++) begin
      if (dec[p].result_forced_zero) begin
        state_next.result[p] = RESULT_ZERO;
      end
    end
    // registered read-back, reserved bits zero
    state_next.cfg_rd    = '0;
    state_next.code_rd   = '0;
    state_next.result_rd = '0;
    if (rd_port_in < PORT_IDX_W'(PORTS)) begin
      state_next.cfg_rd    = state_reg.cfg[rd_port_in];
      state_next.code_rd   = {4'h0, state_reg.code[rd_port_in]};
      state_next.result_rd = {4'h0, state_reg.result[rd_port_in]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////////////////

  // one flop bank, cleared to high impedance mode on reset
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the read port and the front end
  ////////////////////////////////////////////////////////////////////////////

  assign cfg_rd_out    = state_reg.cfg_rd;
  assign code_rd_out   = state_reg.code_rd;
  assign result_rd_out = state_reg.result_rd;

  // per-port controls derived from the decoded words, the stored codes and the level bits
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      port_mode_out[p]      = dec[p].mode;
      port_range_out[p]     = dec[p].range;
      port_ref_sel_out[p]   = dec[p].adc_reference_select;
      port_adc_en_out[p]    = dec[p].adc_enable;
      port_dac_en_out[p]    = dec[p].dac_enable;
      // code is unsigned straight binary, passed unchanged
      port_dac_code_out[p]  = state_reg.code[p];
      // output level bit only acts in mode 3
      port_gpo_level_out[p] = (dec[p].mode == MODE_GPO) && output_level_bits_in[p];
      // mode 9 negative ports borrow the averaging count of the positive port naming them
      port_avg_out[p]       = dec[p].average_count;
      if (dec[p].mode == MODE_ADC_DNEG) begin
        port_avg_out[p] = '0;
        for (int q = 0; q < PORTS; q++) begin
          if ((dec[q].mode == MODE_ADC_DPOS) && (dec[q].assoc_port == PORT_IDX_W'(p))) begin
            port_avg_out[p] = dec[q].average_count;
          end
        end
      end
    end
  end

endmodule : port_mode_config_decode

// File: port_mode_pkg.sv
// package: port configuration word layout, modes and result formatting constants
package port_mode_pkg;

  // port count and data widths
  localparam int NUM_PORTS       = 20;
  localparam int CFG_W           = 16;
  localparam int DATA_W          = 12;
  localparam int PORT_IDX_W      = 5;

  // configuration word field positions
  localparam int SEL_HI          = 15;
  localparam int SEL_LO          = 12;
  localparam int PARAM_HI        = 11;
  localparam int REF_SEL_BIT     = 11;
  localparam int INV_BIT         = 11;
  localparam int RANGE_HI        = 10;
  localparam int RANGE_LO        = 8;
  localparam int AVG_HI          = 7;
  localparam int AVG_LO          = 5;
  localparam int ASSOC_HI        = 4;
  localparam int ASSOC_LO        = 0;

  // reset values
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [11:0] CODE_RESET  = 12'h000;
  localparam logic [11:0] RESULT_ZERO = 12'h000;

  // port functions, in select order 0..12
  typedef enum logic [3:0] {
    MODE_HIZ       = 4'h0,
    MODE_GPI       = 4'h1,
    MODE_BIDIR     = 4'h2,
    MODE_GPO       = 4'h3,
    MODE_PATH_OUT  = 4'h4,
    MODE_DAC_OUT   = 4'h5,
    MODE_DAC_MON   = 4'h6,
    MODE_ADC_SE    = 4'h7,
    MODE_ADC_DPOS  = 4'h8,
    MODE_ADC_DNEG  = 4'h9,
    MODE_ADC_PSEUD = 4'ha,
    MODE_SW_GPI    = 4'hb,
    MODE_SW_REG    = 4'hc
  } port_mode_t;

  // decoded per-port function and fields
  typedef struct packed {
    port_mode_t      mode;
    logic            invert_select;
    logic            adc_reference_select;
    logic [2:0]      range;
    logic [2:0]      average_count;
    logic [4:0]      assoc_port;
    logic            dac_enable;
    logic            adc_enable;
    logic            result_signed;
    logic            result_forced_zero;
  } port_decode_t;

endpackage : port_mode_pkg

// File: port_function_decode.sv
// file: one port's configuration word decoder
`timescale 1ns/1ps
module port_function_decode
  import port_mode_pkg::*;
(
  // configuration word in
  input  wire logic [15:0]  cfg_word_in,
  // decoded function out
  output port_decode_t      decode_out
);

  // combinational field split per mode; undefined fields forced to zero
  always_comb begin
    logic [3:0] sel;
    sel = cfg_word_in[SEL_HI:SEL_LO];
    decode_out = '0;
    // unused select codes fall back to high impedance
    if (sel > 4'hc) begin
      decode_out.mode = MODE_HIZ;
    end else begin
      decode_out.mode = port_mode_t'(sel);
    end
    unique case (decode_out.mode)
      MODE_PATH_OUT, MODE_SW_GPI: begin
        decode_out.invert_select = cfg_word_in[INV_BIT];
        decode_out.assoc_port    = cfg_word_in[ASSOC_HI:ASSOC_LO];
      end
      MODE_DAC_OUT: begin
        decode_out.range      = cfg_word_in[RANGE_HI:RANGE_LO];
        decode_out.dac_enable = 1'b1;
      end
      MODE_DAC_MON: begin
        decode_out.adc_reference_select = cfg_word_in[REF_SEL_BIT];
        decode_out.range                = cfg_word_in[RANGE_HI:RANGE_LO];
        decode_out.dac_enable           = 1'b1;
        decode_out.adc_enable           = 1'b1;
      end
      MODE_ADC_SE: begin
        decode_out.adc_reference_select = cfg_word_in[REF_SEL_BIT];
        decode_out.range                = cfg_word_in[RANGE_HI:RANGE_LO];
        decode_out.average_count        = cfg_word_in[AVG_HI:AVG_LO];
        decode_out.adc_enable           = 1'b1;
      end
      MODE_ADC_DPOS: begin
        decode_out.adc_reference_select = cfg_word_in[REF_SEL_BIT];
        decode_out.range                = cfg_word_in[RANGE_HI:RANGE_LO];
        decode_out.average_count        = cfg_word_in[AVG_HI:AVG_LO];
        decode_out.assoc_port           = cfg_word_in[ASSOC_HI:ASSOC_LO];
        decode_out.adc_enable           = 1'b1;
        decode_out.result_signed        = 1'b1;
      end
      MODE_ADC_DNEG, MODE_ADC_PSEUD: begin
        decode_out.adc_reference_select = cfg_word_in[REF_SEL_BIT];
        decode_out.range                = cfg_word_in[RANGE_HI:RANGE_LO];
        decode_out.dac_enable           = (decode_out.mode == MODE_ADC_PSEUD);
        decode_out.result_forced_zero   = 1'b1;
      end
      default: begin
        // modes 0..3 and 12 carry no parameter fields
        decode_out.dac_enable = (decode_out.mode == MODE_GPO);
      end
    endcase
  end

endmodule : port_function_decode

// File: port_mode_config_decode_monitor.sv
// checker: port-level assertions for the port mode register bank
`timescale 1ns/1ps
module port_mode_config_decode_monitor
  import port_mode_pkg::*;
#(
  parameter int PORTS = NUM_PORTS  // number of ports
)(
  // clock, reset and register ports
  input wire logic                  core_clk_in,
  input wire logic                  rst_b_in,
  input wire logic                  cfg_wr_in,
  input wire logic                  code_wr_in,
  input wire logic [PORT_IDX_W-1:0] wr_port_in,
  input wire logic [15:0]           wr_data_in,
  input wire logic [PORT_IDX_W-1:0] rd_port_in,
  input wire logic [15:0]           code_rd_out,
  input wire logic [15:0]           result_rd_out,
  // converter and port side
  input wire logic [PORTS-1:0]      output_level_bits_in,
  input wire logic                  conv_done_in,
  input wire logic [PORT_IDX_W-1:0] conv_port_in,
  input wire logic [11:0]           conv_raw_in,
  input wire logic [PORTS-1:0][3:0] port_mode_out,
  input wire logic [PORTS-1:0][2:0] port_range_out,
  input wire logic [PORTS-1:0][2:0] port_avg_out,
  input wire logic [PORTS-1:0]      port_ref_sel_out,
  input wire logic [PORTS-1:0]      port_dac_en_out,
  input wire logic [PORTS-1:0][11:0] port_dac_code_out,
  input wire logic [PORTS-1:0]      port_gpo_level_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] wd_q;  // last write data, one cycle late
  logic [4:0]  wp_q;  // last write index, one cycle late
  // delayed copies so consequents need no $past of a slice
  always_ff @(posedge core_clk_in) begin
    wd_q <= wr_data_in;
    wp_q <= wr_port_in;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  a_mode_select: assert property (
    cfg_wr_in && wr_port_in < PORTS |=> port_mode_out[wp_q] == (wd_q[15:12] > 4'hc ? 4'h0 : wd_q[15:12]))
    else $error("mode not taken from select field");
  a_single_fields: assert property (
    cfg_wr_in && wr_port_in < PORTS && wr_data_in[15:12] == 4'h7
    |=> {port_ref_sel_out[wp_q], port_range_out[wp_q], port_avg_out[wp_q]} == wd_q[11:5])
    else $error("single-ended fields wrong");
  a_code_store: assert property (
    code_wr_in && wr_port_in < PORTS |=> port_dac_code_out[wp_q] == wd_q[11:0])
    else $error("output code not stored");
  a_read_upper: assert property (code_rd_out[15:12] == 4'h0 && result_rd_out[15:12] == 4'h0)
    else $error("read upper bits not zero");
  a_neg_zero: assert property (
    (rd_port_in < PORTS && port_mode_out[rd_port_in] inside {4'h9, 4'ha})[*3] |-> result_rd_out == 16'h0000)
    else $error("negative input result not zero");
  a_conv_result: assert property (
    conv_done_in && !cfg_wr_in && conv_port_in == rd_port_in && conv_port_in < PORTS
    && port_mode_out[conv_port_in] inside {4'h6, 4'h7, 4'h8} ##1 $stable(rd_port_in)
    |=> result_rd_out[11:0] == $past(conv_raw_in, 2))
    else $error("conversion result not presented");
  a_gpo_level: assert property (rd_port_in < PORTS |-> port_gpo_level_out[rd_port_in] ==
    (port_mode_out[rd_port_in] == 4'h3 && output_level_bits_in[rd_port_in]))
    else $error("output level wrong");
  a_dac_enable: assert property (
    rd_port_in < PORTS && port_mode_out[rd_port_in] inside {4'h5, 4'h6, 4'ha} |-> port_dac_en_out[rd_port_in])
    else $error("analog output not enabled");
endmodule : port_mode_config_decode_monitor

bind port_mode_config_decode port_mode_config_decode_monitor #(.PORTS(PORTS)) i_monitor (.*);

// File: conv_front_model.sv
// converter front-end model: one raw conversion per request, prompt or slow
`timescale 1ns/1ps
module conv_front_model (
  // request from the bench
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [4:0]  port_in,
  input  wire logic [11:0] raw_in,
  input  wire logic [3:0]  lat_in,
  // result strobe to the bank
  output logic             done_out = 1'b0,
  output logic [4:0]       port_out = 5'h00,
  output logic [11:0]      data_out = 12'h000
);
  logic [3:0]  cnt = 4'h0;  // cycles until the answer
  logic [4:0]  p;           // held port
  logic [11:0] r;           // held result
  // latch a request; lat_in of one or more sets how slow the answer is
  always @(posedge clk_in) begin
    if (req_in) begin
      cnt <= lat_in;
      p <= port_in;
      r <= raw_in;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // one-cycle strobe; lines toggle outside it so stale data never looks valid
  always @(negedge clk_in) begin
    done_out <= (cnt == 4'h1);
    port_out <= (cnt == 4'h1) ? p : ~port_out;
    data_out <= (cnt == 4'h1) ? r : ~data_out;
  end
endmodule : conv_front_model

// File: port_mode_config_decode_tb.sv
// testbench: port mode register bank, scoreboard on the read port
`timescale 1ns/1ps
module port_mode_config_decode_tb;
  import port_mode_pkg::*;
  logic             core_clk_in = 1'b0, rst_b_in = 1'b0, cfg_wr_in = 1'b0, code_wr_in = 1'b0;
  logic             req = 1'b0, pend = 1'b0, tk = 1'b0, conv_done_in;
  logic [4:0]       wr_port_in = 5'h00, rd_port_in = 5'h00, conv_port_in;
  logic [15:0]      wr_data_in = 16'h0000, cfg_rd_out, code_rd_out, result_rd_out, d;
  logic [11:0]      conv_raw_in, raw = 12'h000;
  logic [3:0]       lat = 4'h1;
  logic [19:0]      output_level_bits_in = 20'h00000, port_ref_sel_out, port_adc_en_out;
  logic [19:0]      port_dac_en_out, port_gpo_level_out;
  logic [19:0][3:0] port_mode_out;
  logic [19:0][2:0] port_range_out, port_avg_out;
  logic [19:0][11:0] port_dac_code_out;
  logic [15:0]      cw [20];  // config words written
  logic [56:0]      q [$];    // notes: port, mode, cfg, code, result
  logic [56:0]      n;
  int               error_cnt = 0, cmp_count = 0, seed = 96049, k, j;
  ////////////////////////////////////////////////////////////////////////////
  always #50 core_clk_in = ~core_clk_in;
  port_mode_config_decode i_dut (.*);
  conv_front_model i_conv (.clk_in(core_clk_in), .req_in(req), .port_in(rd_port_in), .raw_in(raw),
    .lat_in(lat), .done_out(conv_done_in), .port_out(conv_port_in), .data_out(conv_raw_in));
  // random level bits keep the output level path busy
  always @(negedge core_clk_in) output_level_bits_in <= 20'($random(seed));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string s, input logic [15:0] e, input logic [15:0] v);
    cmp_count++;
    if (v !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task final_report;
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // config and code written in the same cycle from one data word
  task wr(input logic [4:0] p, input logic [15:0] v);
    @(negedge core_clk_in);
    {cfg_wr_in, code_wr_in, wr_port_in, wr_data_in} = {2'b11, p, v};
    @(negedge core_clk_in);
    {cfg_wr_in, code_wr_in} = 2'b00;
  endtask : wr
  // select a port and note what the read registers must show
  task rd(input logic [4:0] p, input logic [3:0] m, input logic [15:0] c, input logic [15:0] r);
    @(negedge core_clk_in);
    rd_port_in = p;
    pend = 1'b1;
    q.push_back({p, m, c, 4'h0, c[11:0], r});
    @(negedge core_clk_in);
    pend = 1'b0;
  endtask : rd
  // watcher: read outputs settle one edge after the index
  always @(posedge core_clk_in) tk <= pend;
  always @(negedge core_clk_in) begin
    if (tk) begin
      n = q.pop_front();
      // an index past the last port has no mode output; it must read as mode 0
      chk("mode", {12'h000, n[51:48]}, (n[56:52] < 5'd20) ? {12'h000, port_mode_out[n[56:52]]} : 16'h0000);
      chk("cfg", n[47:32], cfg_rd_out);
      chk("code", n[31:16], code_rd_out);
      chk("result", n[15:0], result_rd_out);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    for (k = 0; k < 21; k++) rd(k[4:0], 4'h0, 16'h0000, 16'h0000);
    $display("test reset values done");
    // every select, selects 13..15 fall back to high impedance
    for (k = 0; k < 16; k++) begin
      d = 16'($random(seed));
      d[15:12] = k[3:0];
      cw[k] = d;
      wr(k[4:0], d);
      rd(k[4:0], (k > 12) ? 4'h0 : k[3:0], d, 16'h0000);
    end
    $display("test mode select done");
    // conversions, prompt and slow; only modes 6..8 keep a result
    for (k = 5; k < 11; k++) begin
      raw = 12'($random(seed));
      lat = k[0] ? 4'h1 : 4'h5;
      @(negedge core_clk_in);
      rd_port_in = k[4:0];
      req = 1'b1;
      @(negedge core_clk_in);
      req = 1'b0;
      for (j = 0; j < 10 && conv_done_in !== 1'b1; j++) @(negedge core_clk_in);
      if (j == 10) begin
        error_cnt++;
        final_report();
      end
      rd(k[4:0], k[3:0], cw[k], (k > 5 && k < 9) ? {4'h0, raw} : 16'h0000);
    end
    $display("test conversion done");
    @(negedge core_clk_in);
    rst_b_in = 1'b0;
    @(negedge core_clk_in);
    rst_b_in = 1'b1;
    for (k = 0; k < 20; k++) rd(k[4:0], 4'h0, 16'h0000, 16'h0000);
    $display("test second reset done");
    final_report();
  end
endmodule : port_mode_config_decode_tb
